// ===== hw/dutc_pkg.sv
// Purpose: Shared constants for the converter update trigger control block.
// Assumes: 100 MHz clock, Avalon-MM register slave with byte addresses.
// Notes: Offsets are aligned word byte addresses.
package dutc_pkg;
  localparam int CODE_W = 10;
  localparam int BYTE_W = 8;
  localparam int ADDR_W = 4;
  localparam int DATA_W = 32;
  localparam int NUM_TRIG = 8;
  localparam int SEL_W = 3;

  localparam logic [ADDR_W-1:0] OFS_CONTROL = 4'h0;
  localparam logic [ADDR_W-1:0] OFS_VALUE_LOW = 4'h4;
  localparam logic [ADDR_W-1:0] OFS_VALUE_HIGH = 4'h8;
  localparam logic [ADDR_W-1:0] OFS_STATUS = 4'hC;

  localparam int BIT_CONVERTER_EN = 0;
  localparam int BIT_PIN_OUTPUT_EN = 1;
  localparam int BIT_LEFT_ALIGN = 2;
  localparam int BIT_SEL_LSB = 4;
  localparam int BIT_SEL_MSB = 6;
  localparam int BIT_AUTO_TRIGGER_EN = 7;
  localparam logic [7:0] CONTROL_WMASK = 8'hF7;

  localparam logic [7:0] CONTROL_RESET = 8'h00;
  localparam logic [7:0] VALUE_RESET = 8'h00;

  localparam int BIT_STAT_BUSY = 0;
  localparam int BIT_STAT_ARMED = 1;

  localparam int CLK_PERIOD_NS = 10;
  localparam int SETTLE_NS = 1000;
  localparam int SETTLE_CYCLES = (SETTLE_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
endpackage : dutc_pkg

// ===== hw/dutc_settle.sv
// Purpose: Counts the output settling window after each accepted update.
// Assumes: start is a one-cycle pulse; enable is the converter enable bit.
// Notes: Busy drops at the next clock edge after the converter is disabled.
`timescale 1ns/100ps
module dutc_settle
  import dutc_pkg::*;
#(
  parameter int CYCLES = SETTLE_CYCLES
) (
  // Clock and reset
  input wire logic clk,
  input wire logic rst,
  // Control
  input wire logic start,
  input wire logic enable,
  // Status
  output logic busy
);
  localparam int CW = $clog2(CYCLES + 1);
  localparam logic [CW-1:0] LOAD = CW'(CYCLES);

  logic [CW-1:0] cnt;
  logic [CW-1:0] next_cnt;

  always_comb begin
    next_cnt = cnt;
    if (!enable) begin
      next_cnt = '0;
    end else if (start) begin
      next_cnt = LOAD;
    end else if (cnt != '0) begin
      next_cnt = cnt - CW'(1);
    end
  end

  always_ff @(posedge clk) begin
    if (rst) begin
      cnt <= '0;
    end else begin
      cnt <= next_cnt;
    end
  end

  assign busy = (cnt != '0);
endmodule : dutc_settle

// ===== hw/dutc_top.sv
// Purpose: Control for a 10-bit converter: registers, shadow code, triggers.
// Assumes: Single clock, synchronous inputs, Avalon-MM with waitrequest.
// Notes: Every access waits exactly one cycle before it completes.
// Summary of operation
// - Enable bit starts converting the held code
// - Auto mode: trigger edge updates; else high write
// - Three-bit select picks one of eight events
// - Select field ignored unless auto mode set
// - Flag rising edge triggers, interrupt masking irrelevant
// - Edges during conversion ignored; level never retriggers
// - Align bit chooses left or right data placement
// - Align change applies at next update (high write or auto trigger)
// - Pin enable routes result to analog pin while enable bit set
// - Low byte write alone never changes output
// - Left aligned: one high write updates value
// - Converter code is ten bits wide
// - Hidden shadow loads only on update events
// - Auto trigger waits for low then high write
`timescale 1ns/100ps
module dutc_top
  import dutc_pkg::*;
#(
  parameter int SETTLE = SETTLE_CYCLES
) (
  // Clock and reset
  input wire logic clk,
  input wire logic rst,
  // Avalon-MM slave
  input wire logic [ADDR_W-1:0] address,
  input wire logic read,
  input wire logic write,
  input wire logic [DATA_W-1:0] writedata,
  input wire logic [3:0] byteenable,
  output logic [DATA_W-1:0] readdata,
  output logic waitrequest,
  // Event flags, levels
  input wire logic [NUM_TRIG-1:0] trig_flags,
  // Converter side
  output logic [CODE_W-1:0] dac_code,
  output logic dac_enable,
  output logic analog_out_pin_en,
  output logic conv_busy,
  output logic update_pulse
);

  // Returns the converter code held by a register pair for one alignment.
  function automatic logic [CODE_W-1:0] pair_code(
    input logic [7:0] hi,
    input logic [7:0] lo,
    input logic la
  );
    if (la) begin
      pair_code = {hi, lo[7:6]};
    end else begin
      pair_code = {hi[1:0], lo};
    end
  endfunction : pair_code

  logic [7:0] converter_control;
  logic [7:0] value_high;
  logic [7:0] value_low;
  logic [CODE_W-1:0] shadow;
  logic armed;
  logic [NUM_TRIG-1:0] flag_prev;
  logic ack;
  logic upd_q;
  logic [DATA_W-1:0] rdata;

  logic [7:0] next_converter_control;
  logic [7:0] next_value_high;
  logic [7:0] next_value_low;
  logic [CODE_W-1:0] next_shadow;
  logic next_armed;
  logic next_ack;
  logic [DATA_W-1:0] next_rdata;

  logic req;
  logic acc_wr;
  logic ctrl_wr;
  logic hi_wr;
  logic lo_wr;
  logic auto_trigger_en;
  logic left_align;
  logic converter_en;
  logic pin_output_en;
  logic [SEL_W-1:0] trigger_select;
  logic trig_edge;
  logic manual_upd;
  logic trig_upd;
  logic load;

  assign converter_en = converter_control[BIT_CONVERTER_EN];
  assign pin_output_en = converter_control[BIT_PIN_OUTPUT_EN];
  assign left_align = converter_control[BIT_LEFT_ALIGN];
  assign auto_trigger_en = converter_control[BIT_AUTO_TRIGGER_EN];
  assign trigger_select = converter_control[BIT_SEL_MSB:BIT_SEL_LSB];

  // A request is held one cycle so read data can come from a flip-flop.
  assign req = read | write;
  assign waitrequest = req & ~ack;
  assign acc_wr = write & ack & byteenable[0];
  assign ctrl_wr = acc_wr & (address == OFS_CONTROL);
  assign hi_wr = acc_wr & (address == OFS_VALUE_HIGH);
  assign lo_wr = acc_wr & (address == OFS_VALUE_LOW);

  // Flags are compared with their own past so a level held high is not an
  // event; the selected index is only looked at in auto mode.
  assign trig_edge = auto_trigger_en
                   & trig_flags[trigger_select]
                   & ~flag_prev[trigger_select];

  assign manual_upd = hi_wr & ~auto_trigger_en;
  assign trig_upd = trig_edge & armed & ~conv_busy;
  assign load = manual_upd | trig_upd;

  always_comb begin
    next_ack = req & ~ack;
    next_rdata = '0;
    if (req & ~ack & read) begin
      unique case (address)
        OFS_CONTROL: next_rdata[7:0] = converter_control;
        OFS_VALUE_LOW: next_rdata[7:0] = value_low;
        OFS_VALUE_HIGH: next_rdata[7:0] = value_high;
        OFS_STATUS: begin
          next_rdata[BIT_STAT_BUSY] = conv_busy;
          next_rdata[BIT_STAT_ARMED] = armed;
        end
        default: next_rdata = '0;
      endcase
    end else if (ack) begin
      next_rdata = rdata;
    end
  end

  always_comb begin
    next_converter_control = converter_control;
    next_value_high = value_high;
    next_value_low = value_low;
    if (ctrl_wr) begin
      next_converter_control = writedata[7:0] & CONTROL_WMASK;
    end
    if (hi_wr) begin
      next_value_high = writedata[7:0];
    end
    if (lo_wr) begin
      next_value_low = writedata[7:0];
    end
  end

  // The shadow is the only thing the converter sees; it is not mapped.
  always_comb begin
    next_shadow = shadow;
    next_armed = armed;
    if (lo_wr) begin
      next_armed = 1'b0;
    end else if (hi_wr) begin
      next_armed = 1'b1;
    end
    if (manual_upd) begin
      // Alignment is taken as it stands at this write.
      next_shadow = pair_code(writedata[7:0], value_low, left_align);
    end else if (trig_upd) begin
      next_shadow = pair_code(value_high, value_low, left_align);
    end
  end

  always_ff @(posedge clk) begin
    if (rst) begin
      converter_control <= CONTROL_RESET;
      value_high <= VALUE_RESET;
      value_low <= VALUE_RESET;
      shadow <= '0;
      armed <= 1'b0;
      flag_prev <= '0;
      ack <= 1'b0;
      upd_q <= 1'b0;
      rdata <= '0;
    end else begin
      converter_control <= next_converter_control;
      value_high <= next_value_high;
      value_low <= next_value_low;
      shadow <= next_shadow;
      armed <= next_armed;
      flag_prev <= trig_flags;
      ack <= next_ack;
      upd_q <= load;
      rdata <= next_rdata;
    end
  end

  dutc_settle #(
    .CYCLES(SETTLE)
  ) u_settle (
    .clk(clk),
    .rst(rst),
    .start(load),
    .enable(converter_en),
    .busy(conv_busy)
  );

  assign readdata = rdata;
  assign dac_code = shadow;
  assign dac_enable = converter_en;
  assign analog_out_pin_en = converter_en & pin_output_en;
  assign update_pulse = upd_q;

  // Checks below hold the cycle behaviour described above.
  logic [7:0] wd_q;
  always_ff @(posedge clk) begin
    wd_q <= writedata[7:0];
  end

  default clocking cb @(posedge clk);
  endclocking
  default disable iff (rst);

  chk_low_no_update: assert property (
    lo_wr && !trig_upd |=> $stable(dac_code))
    else $error("Low byte write changed the code.");

  chk_manual_update: assert property (
    hi_wr && !auto_trigger_en |=> update_pulse)
    else $error("High byte write did not update in normal mode.");

  chk_busy_ignore: assert property (
    auto_trigger_en && conv_busy |=> !update_pulse)
    else $error("Trigger accepted during a conversion.");

  chk_select_ignored: assert property (
    !auto_trigger_en && !hi_wr |=> !update_pulse)
    else $error("Update without high write outside auto mode.");

  chk_unarmed_hold: assert property (
    auto_trigger_en && !armed && !hi_wr |=> $stable(dac_code))
    else $error("Trigger loaded code before high byte write.");

  chk_trigger_edge: assert property (
    auto_trigger_en && armed && !conv_busy
    && trig_flags[trigger_select] && !flag_prev[trigger_select]
    |=> update_pulse ##1 conv_busy || !dac_enable)
    else $error("Selected flag edge did not update.");

  chk_busy_window: assert property (
    load && converter_en && !ctrl_wr |=> conv_busy [*8])
    else $error("Conversion window ended early.");

  chk_disabled_idle: assert property (
    !dac_enable |=> !conv_busy || dac_enable)
    else $error("Busy while converter disabled.");

  chk_pin_route: assert property (
    ctrl_wr && writedata[1:0] == 2'h3 |=> analog_out_pin_en)
    else $error("Analog pin not enabled.");

  chk_align_defer: assert property (
    ctrl_wr && !auto_trigger_en |=> $stable(dac_code))
    else $error("Control write changed code directly.");

  chk_right_align: assert property (
    manual_upd && !left_align |=> dac_code[9:8] == wd_q[1:0])
    else $error("Right aligned high bits misplaced.");

  chk_left_align: assert property (
    manual_upd && left_align |=> dac_code[9:2] == wd_q)
    else $error("Left aligned high byte misplaced.");

  // Arming follows the last data byte written, whatever the mode.
  chk_one_wait: assert property (
    (read || write) && waitrequest |=> !waitrequest)
    else $error("Bus request waited more than one cycle.");

  chk_read_upper: assert property (
    read && !waitrequest |-> readdata[DATA_W-1:BYTE_W] == '0)
    else $error("Read data upper bits not zero.");

  chk_level_hold: assert property (
    auto_trigger_en && trig_flags[trigger_select]
    && flag_prev[trigger_select] |=> !update_pulse)
    else $error("Held trigger level started an update.");

  chk_low_disarm: assert property (
    lo_wr |=> !armed)
    else $error("Low byte write left the trigger armed.");

  chk_high_arm: assert property (
    hi_wr |=> armed)
    else $error("High byte write did not arm the trigger.");

  chk_pin_gate: assert property (
    !pin_output_en || !converter_en |-> !analog_out_pin_en)
    else $error("Analog pin enabled without both bits.");

  chk_single_pulse: assert property (
    update_pulse |=> !update_pulse)
    else $error("Update pulse lasted more than one cycle.");

  cov_manual: cover property (hi_wr && !auto_trigger_en ##1 update_pulse);
  cov_trigger: cover property (trig_upd ##1 update_pulse);
  cov_ignored: cover property (trig_edge && armed && conv_busy);
  cov_left: cover property (manual_upd && left_align);
  cov_disarmed: cover property (lo_wr ##1 !armed);
endmodule : dutc_top

// ===== bench/dutc_top_tb.sv
// Purpose: Self-checking bench for the converter update trigger block.
// Assumes: Offsets and control bit positions come from dutc_pkg.
// Notes: Settle window cut to 10 cycles so trigger tests stay short.
`timescale 1ns/100ps
module dutc_top_tb
  import dutc_pkg::*;
;
  localparam int SET = 10;
  logic clk, rst, read, write, waitrequest, dac_enable, pin_en;
  logic conv_busy, update_pulse;
  logic [ADDR_W-1:0] address;
  logic [DATA_W-1:0] writedata, readdata;
  logic [3:0] byteenable;
  logic [NUM_TRIG-1:0] trig_flags, oth, sel;
  logic [CODE_W-1:0] dac_code;
  int mismatches = 0;
  int checks_done = 0;
  int cycles = 0;

  dutc_top #(.SETTLE(SET)) i_dutc_top (
    .clk(clk), .rst(rst), .address(address), .read(read),
    .write(write), .writedata(writedata), .byteenable(byteenable),
    .readdata(readdata), .waitrequest(waitrequest),
    .trig_flags(trig_flags), .dac_code(dac_code),
    .dac_enable(dac_enable), .analog_out_pin_en(pin_en),
    .conv_busy(conv_busy), .update_pulse(update_pulse)
  );

  initial begin
    clk = 1'b0;
    forever #5 clk = ~clk;
  end

  task automatic close_out();
    $display("checks %0d mismatches %0d", checks_done, mismatches);
    if (mismatches == 0 && checks_done > 0) begin
      $display("Finished cleanly");
    end else begin
      $display("Finished with errors");
    end
    $finish;
  endtask : close_out

  // The ceiling is far above the few hundred cycles the tests need.
  always @(posedge clk) begin
    cycles++;
    if (cycles == 5000) begin
      mismatches++;
      $display("BAD %0t timeout", $time);
      close_out();
    end
  end

  task automatic chk(input logic [31:0] got, exp, input string m);
    checks_done++;
    if (got !== exp) begin
      mismatches++;
      $display("BAD %0t %s got %h exp %h", $time, m, got, exp);
    end
  endtask : chk

  // One edge passes after release so back-to-back calls never collide.
  task automatic wr(input logic [3:0] a, input logic [7:0] d,
                    input logic [3:0] be = 4'hF);
    address <= a;
    writedata <= {24'h0, d};
    byteenable <= be;
    write <= 1'b1;
    do @(posedge clk); while (waitrequest !== 1'b0);
    write <= 1'b0;
    @(posedge clk);
  endtask : wr

  task automatic rdc(input logic [3:0] a, input logic [31:0] exp,
                     input string m);
    logic [31:0] v;
    address <= a;
    read <= 1'b1;
    do @(posedge clk); while (waitrequest !== 1'b0);
    v = readdata;
    read <= 1'b0;
    @(posedge clk);
    chk(v, exp, m);
  endtask : rdc

  // Drives the flags and counts update pulses over the next four edges.
  // Pulses are sampled as they stood just before each edge the task waits on,
  // so a pulse raised at the last edge of the previous call is counted here.
  task automatic pulse(input logic [7:0] f, input int n, input string m);
    int seen;
    seen = 0;
    trig_flags <= f;
    repeat (4) begin
      @(posedge clk);
      if (update_pulse === 1'b1) seen++;
    end
    chk(32'(seen), 32'(n), m);
  endtask : pulse

  task automatic idle();
    for (int i = 0; i < 40 && conv_busy !== 1'b0; i++) @(posedge clk);
    chk({31'h0, conv_busy}, 32'h0, "busy end");
  endtask : idle

  initial begin
    rst = 1'b1;
    read = 1'b0;
    write = 1'b0;
    address = '0;
    writedata = '0;
    byteenable = '0;
    trig_flags = '0;
    repeat (5) @(posedge clk);
    rst <= 1'b0;
    @(posedge clk);
    rdc(OFS_CONTROL, 32'h0, "ctrl reset");
    rdc(OFS_VALUE_HIGH, 32'h0, "high reset");
    wr(OFS_CONTROL, 8'hFF);
    rdc(OFS_CONTROL, 32'hF7, "ctrl mask");
    rdc(4'h1, 32'h0, "unmapped");
    wr(OFS_CONTROL, 8'h01);
    chk({31'h0, dac_enable}, 32'h1, "enable");
    chk({31'h0, pin_en}, 32'h0, "pin off");
    wr(OFS_VALUE_LOW, 8'hAB);
    chk(32'(dac_code), 32'h0, "low only");
    wr(OFS_VALUE_HIGH, 8'h03);
    chk(32'(dac_code), 32'h3AB, "right align");
    wr(OFS_VALUE_HIGH, 8'h01, 4'h0);
    rdc(OFS_VALUE_HIGH, 32'h3, "lane off");
    wr(OFS_CONTROL, 8'h07);
    chk({31'h0, pin_en}, 32'h1, "pin on");
    chk(32'(dac_code), 32'h3AB, "align held");
    wr(OFS_VALUE_HIGH, 8'h80);
    chk(32'(dac_code), 32'h202, "left align");
    pulse(8'h01, 0, "normal trig");
    pulse(8'h00, 0, "normal fall");
    $display("test normal done");
    for (int s = 0; s < 8; s++) begin
      sel = 8'(1 << s);
      oth = 8'(1 << ((s + 1) % 8));
      wr(OFS_CONTROL, 8'(8'h81 | (s << 4)));
      wr(OFS_VALUE_LOW, 8'(s));
      wr(OFS_VALUE_HIGH, 8'h01);
      pulse(oth, 0, "other flag");
      pulse(oth | sel, 1, "selected");
      chk(32'(dac_code), 32'h100 + 32'(s), "trig code");
      chk({31'h0, conv_busy}, 32'h1, "busy");
      pulse(oth, 0, "fall busy");
      pulse(oth | sel, 0, "edge busy");
      idle();
      pulse(oth | sel, 0, "held level");
      pulse(8'h00, 0, "flag clear");
    end
    $display("test select done");
    wr(OFS_VALUE_LOW, 8'h3C);
    pulse(8'h80, 0, "disarmed");
    pulse(8'h00, 0, "clear");
    wr(OFS_VALUE_HIGH, 8'h02);
    chk(32'(dac_code), 32'h107, "auto hold");
    pulse(8'h80, 1, "armed");
    chk(32'(dac_code), 32'h23C, "pair code");
    idle();
    pulse(8'h00, 0, "clear");
    pulse(8'h80, 1, "again");
    rdc(OFS_STATUS, 32'h3, "status");
    $display("test arm done");
    wr(OFS_CONTROL, 8'h00);
    chk({31'h0, dac_enable}, 32'h0, "disable");
    chk({31'h0, pin_en}, 32'h0, "pin off");
    $display("test disable done");
    close_out();
  end
endmodule : dutc_top_tb
